// ==== logic/ptm_pkg.sv ====
// Constants, field positions and carrier types of the pulse timer module.
// Assumes an 8-bit register port with eight byte registers.
package ptm_pkg;

   localparam int unsigned ADDR_W = 3;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CNT_W  = 16;

   // Register offsets
   localparam logic [2:0] TSC_OFS  = 3'h0;
   localparam logic [2:0] CNTH_OFS = 3'h1;
   localparam logic [2:0] CNTL_OFS = 3'h2;
   localparam logic [2:0] MODH_OFS = 3'h3;
   localparam logic [2:0] MODL_OFS = 3'h4;
   localparam logic [2:0] CSC_OFS  = 3'h5;
   localparam logic [2:0] CVH_OFS  = 3'h6;
   localparam logic [2:0] CVL_OFS  = 3'h7;

   // Timer status/control fields
   localparam int unsigned OVF_BIT   = 7;
   localparam int unsigned OVFIE_BIT = 6;
   localparam int unsigned CPWM_BIT  = 5;
   localparam int unsigned CSRC_HI   = 4;
   localparam int unsigned CSRC_LO   = 3;
   localparam int unsigned PRE_HI    = 2;
   localparam int unsigned PRE_LO    = 0;

   // Channel status/control fields
   localparam int unsigned CFLAG_BIT = 7;
   localparam int unsigned CIE_BIT   = 6;
   localparam int unsigned MSB_BIT   = 5;
   localparam int unsigned MSA_BIT   = 4;
   localparam int unsigned ELS_HI    = 3;
   localparam int unsigned ELS_LO    = 2;

   // Reset values and counter landmarks
   localparam logic [15:0] MOD_RST   = 16'h0000;
   localparam logic [15:0] CNT_RST   = 16'h0000;
   localparam logic [15:0] CVAL_RST  = 16'h0000;
   localparam logic [7:0]  TSC_RST   = 8'h00;
   localparam logic [7:0]  CSC_RST   = 8'h00;
   localparam logic [15:0] FREE_TOP  = 16'hFFFF;
   localparam logic [15:0] FREE_PRE  = 16'hFFFE;
   localparam logic [6:0]  PRE_RST   = 7'h00;

   typedef enum logic [1:0] {
      CS_NONE  = 2'h0,
      CS_BUS   = 2'h1,
      CS_FIXED = 2'h2,
      CS_EXT   = 2'h3
   } ptm_csrc_t;

   typedef enum logic [3:0] {
      MODE_CAPT = 4'b0001,
      MODE_COMP = 4'b0010,
      MODE_EPWM = 4'b0100,
      MODE_CPWM = 4'b1000
   } ptm_mode_t;

   typedef enum logic [1:0] {
      ELS_OFF  = 2'h0,
      ELS_RISE = 2'h1,
      ELS_FALL = 2'h2,
      ELS_BOTH = 2'h3
   } ptm_els_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wData;
      logic              wr;
      logic              rd;
   } ptm_bus_t;

endpackage

// ==== logic/ptm_timer.sv ====
// Pulse timer module: 16-bit counter with coherent modulo, one channel.
// Assumes a register master per ptm_bus_t, inputs synchronous to clk.
//
// Summary of operation
// - Counter at modulo wraps to zero outside center mode, sets overflow
// - Half-written modulo suppresses overflow flag and interrupt
// - Reset clears modulo, counter runs free
// - No clock: modulo updates on second byte
// - Clocked: buffered modulo loads at modulo-1 to modulo
// - Free running: buffered modulo loads at FFFE to FFFF
// - Status/control write resets modulo byte latching
// - Debug halt freezes modulo latch state; status/control write still resets it
// - Debug halt: modulo writes go straight through
// - Capture edge sets channel event flag
// - Compare or PWM match sets channel flag
// - PWM at 0% or 100% sets no flag
// - Flag with enable requests channel interrupt
// - Read-then-write-zero clears flag; new event wins
// - Writing one ignored; reset clears flag
// - Mode-select-B without center mode gives edge PWM
// - Mode-select-A picks capture or compare
// - Edge/level field sets edge, match level, polarity
// - Edge/level zero releases pin, flag still works outside capture mode
// - Clock select: none, bus, fixed, external
// - Edge/level decode for capture and compare
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module ptm_timer
(
   input  wire logic            clk,         // Bus clock, 40 MHz
   input  wire logic            srst,        // Synchronous reset, active high
   input  wire ptm_pkg::ptm_bus_t busReq,    // Register port request
   output logic [7:0]           rdData,      // Read data, cycle after read strobe
   input  wire logic            debugHalt,   // Debug halt state active
   input  wire logic            fixedTick,   // Fixed-frequency clock enable pulse
   input  wire logic            extTick,     // External clock enable pulse
   input  wire logic            chanIn,      // Channel pin input level
   output logic                 chanOut,     // Channel pin output level
   output logic                 chanOe,      // Channel pin output enable
   output logic                 overflowIrq, // Overflow interrupt request
   output logic                 chanIrq      // Channel interrupt request
);
   import ptm_pkg::*;

   // Timer state
   logic [7:0]  tscReg, tscNext;
   logic [15:0] cntReg, cntNext;
   logic        downReg, downNext;
   logic [6:0]  preReg, preNext;
   logic        ovfArmReg, ovfArmNext;
   // Modulo coherency
   logic [15:0] modReg, modNext;
   logic [15:0] modBufReg, modBufNext;
   logic        hiWrReg, hiWrNext;
   logic        loWrReg, loWrNext;
   // Channel
   logic [7:0]  cscReg, cscNext;
   logic [15:0] cvalReg, cvalNext;
   logic        chArmReg, chArmNext;
   logic        inPrevReg;
   logic        outReg, outNext;
   logic [7:0]  rdReg, rdNext;

   logic        wrTsc, wrCnt, wrModH, wrModL, wrCsc, wrCvh, wrCvl;
   logic        rdTsc, rdCsc;
   logic        srcTick, tick, ovfEvent, modInhibit, modLoad;
   logic        chEvent, match, pwmExtreme;
   logic [6:0]  preMask;
   logic [15:0] topVal;
   ptm_csrc_t   csrc;
   ptm_mode_t   mode;
   ptm_els_t    els;

   // Address decode
   always_comb
   begin
      wrTsc  = 1'b0;
      wrCnt  = 1'b0;
      wrModH = 1'b0;
      wrModL = 1'b0;
      wrCsc  = 1'b0;
      wrCvh  = 1'b0;
      wrCvl  = 1'b0;
      if (busReq.wr)
      begin
         if (busReq.addr == TSC_OFS)
            wrTsc = 1'b1;
         else if (busReq.addr == CNTH_OFS || busReq.addr == CNTL_OFS)
            wrCnt = 1'b1;
         else if (busReq.addr == MODH_OFS)
            wrModH = 1'b1;
         else if (busReq.addr == MODL_OFS)
            wrModL = 1'b1;
         else if (busReq.addr == CSC_OFS)
            wrCsc = 1'b1;
         else if (busReq.addr == CVH_OFS)
            wrCvh = 1'b1;
         else
            wrCvl = 1'b1;
      end
      rdTsc = busReq.rd && (busReq.addr == TSC_OFS);
      rdCsc = busReq.rd && (busReq.addr == CSC_OFS);
   end

   // Clock source and prescaler
   always_comb
   begin
      csrc = ptm_csrc_t'(tscReg[CSRC_HI:CSRC_LO]);
      case (csrc)
         CS_NONE:  srcTick = 1'b0;
         CS_BUS:   srcTick = 1'b1;
         CS_FIXED: srcTick = fixedTick;
         default:  srcTick = extTick;
      endcase
      preMask = 7'(8'h7F >> (3'h7 - tscReg[PRE_HI:PRE_LO]));
      // Counter frozen in debug halt
      tick    = srcTick && !debugHalt && ((preReg & preMask) == preMask);
      preNext = preReg;
      if (srcTick && !debugHalt)
         preNext = (preReg & preMask) == preMask ? PRE_RST : preReg + 7'h01;
      if (wrCnt)
         preNext = PRE_RST;
   end

   // Counter
   always_comb
   begin
      topVal   = (modReg == MOD_RST) ? FREE_TOP : modReg;
      cntNext  = cntReg;
      downNext = downReg;
      ovfEvent = 1'b0;
      if (tick)
      begin
         if (!tscReg[CPWM_BIT])
         begin
            // Also wraps at FFFF when modulo is set below the count
            if (cntReg == topVal || cntReg == FREE_TOP)
            begin
               cntNext  = CNT_RST;
               ovfEvent = 1'b1;
            end
            else
               cntNext = cntReg + 16'h0001;
         end
         else if (!downReg)
         begin
            if (cntReg >= topVal)
            begin
               cntNext  = cntReg - 16'h0001;
               downNext = 1'b1;
               ovfEvent = 1'b1;
            end
            else
               cntNext = cntReg + 16'h0001;
         end
         else if (cntReg == CNT_RST)
         begin
            cntNext  = cntReg + 16'h0001;
            downNext = 1'b0;
         end
         else
            cntNext = cntReg - 16'h0001;
      end
      if (wrCnt)
      begin
         cntNext  = CNT_RST;
         downNext = 1'b0;
      end
   end

   // Modulo double buffer
   always_comb
   begin
      modNext    = modReg;
      modBufNext = modBufReg;
      hiWrNext   = hiWrReg;
      loWrNext   = loWrReg;
      // Overflow held off between the two byte writes
      modInhibit = hiWrReg ^ loWrReg;
      // Pending value loads as the count steps into the top
      modLoad    = hiWrReg && loWrReg && tick && !downReg
                   && (cntReg == topVal - 16'h0001);
      if (modLoad)
      begin
         modNext  = modBufReg;
         hiWrNext = 1'b0;
         loWrNext = 1'b0;
      end
      if (debugHalt)
      begin
         // Latch flags untouched, bytes go straight to the active value
         if (wrModH)
            modNext[15:8] = busReq.wData;
         if (wrModL)
            modNext[7:0] = busReq.wData;
      end
      else
      begin
         if (wrModH)
         begin
            modBufNext[15:8] = busReq.wData;
            hiWrNext         = 1'b1;
         end
         if (wrModL)
         begin
            modBufNext[7:0] = busReq.wData;
            loWrNext        = 1'b1;
         end
         if (csrc == CS_NONE && hiWrNext && loWrNext)
         begin
            modNext  = modBufNext;
            hiWrNext = 1'b0;
            loWrNext = 1'b0;
         end
      end
      if (wrTsc)
      begin
         hiWrNext = 1'b0;
         loWrNext = 1'b0;
      end
   end

   // Timer status/control and overflow flag
   always_comb
   begin
      tscNext    = tscReg;
      ovfArmNext = ovfArmReg;
      if (rdTsc && tscReg[OVF_BIT])
         ovfArmNext = 1'b1;
      if (wrTsc)
      begin
         tscNext[6:0] = busReq.wData[6:0];
         if (ovfArmReg && !busReq.wData[OVF_BIT])
            tscNext[OVF_BIT] = 1'b0;
         ovfArmNext = 1'b0;
      end
      // A new overflow wins over a clear in the same cycle
      if (ovfEvent && !modInhibit)
      begin
         tscNext[OVF_BIT] = 1'b1;
         ovfArmNext       = 1'b0;
      end
   end

   // Channel mode decode
   always_comb
   begin
      els = ptm_els_t'(cscReg[ELS_HI:ELS_LO]);
      if (tscReg[CPWM_BIT])
         mode = MODE_CPWM;
      else if (cscReg[MSB_BIT])
         mode = MODE_EPWM;
      else if (cscReg[MSA_BIT])
         mode = MODE_COMP;
      else
         mode = MODE_CAPT;
      match      = tick && (cntNext == cvalReg);
      pwmExtreme = (cvalReg == CVAL_RST) || (cvalReg > topVal);
   end

   // Channel event, flag, value and pin
   always_comb
   begin
      cscNext   = cscReg;
      cvalNext  = cvalReg;
      chArmNext = chArmReg;
      outNext   = outReg;
      chEvent   = 1'b0;
      case (mode)
         MODE_CAPT:
         begin
            // Capture is on synchronous input levels
            if (((els == ELS_RISE || els == ELS_BOTH) && chanIn && !inPrevReg)
                || ((els == ELS_FALL || els == ELS_BOTH) && !chanIn && inPrevReg))
            begin
               chEvent  = 1'b1;
               cvalNext = cntReg;
            end
         end
         MODE_COMP:
         begin
            if (match)
            begin
               chEvent = 1'b1;
               case (els)
                  ELS_RISE: outNext = !outReg;
                  ELS_FALL: outNext = 1'b0;
                  ELS_BOTH: outNext = 1'b1;
                  default:  outNext = outReg;
               endcase
            end
         end
         MODE_EPWM:
         begin
            if (ovfEvent)
               outNext = (cvalReg == CVAL_RST) ? els[0] : !els[0];
            else if (match)
               outNext = els[0];
            chEvent = match && !pwmExtreme;
         end
         default:
         begin
            if (match)
               outNext = downNext ? !els[0] : els[0];
            chEvent = match && !pwmExtreme;
         end
      endcase
      if (rdCsc && cscReg[CFLAG_BIT])
         chArmNext = 1'b1;
      if (wrCsc)
      begin
         cscNext[6:0] = busReq.wData[6:0];
         // Writing one leaves the flag alone
         if (chArmReg && !busReq.wData[CFLAG_BIT])
            cscNext[CFLAG_BIT] = 1'b0;
         chArmNext = 1'b0;
      end
      if (chEvent)
      begin
         cscNext[CFLAG_BIT] = 1'b1;
         chArmNext          = 1'b0;
      end
      // Value writes ignored while capturing
      if (mode != MODE_CAPT)
      begin
         if (wrCvh)
            cvalNext[15:8] = busReq.wData;
         if (wrCvl)
            cvalNext[7:0] = busReq.wData;
      end
   end

   // Read mux, data stands one cycle after the strobe
   always_comb
   begin
      rdNext = 8'h00;
      if (busReq.rd)
      begin
         if (busReq.addr == TSC_OFS)
            rdNext = tscReg;
         else if (busReq.addr == CNTH_OFS)
            rdNext = cntReg[15:8];
         else if (busReq.addr == CNTL_OFS)
            rdNext = cntReg[7:0];
         else if (busReq.addr == MODH_OFS)
            rdNext = modReg[15:8];
         else if (busReq.addr == MODL_OFS)
            rdNext = modReg[7:0];
         else if (busReq.addr == CSC_OFS)
            rdNext = cscReg;
         else if (busReq.addr == CVH_OFS)
            rdNext = cvalReg[15:8];
         else
            rdNext = cvalReg[7:0];
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         tscReg    <= TSC_RST;
         cntReg    <= CNT_RST;
         downReg   <= 1'b0;
         preReg    <= PRE_RST;
         ovfArmReg <= 1'b0;
         modReg    <= MOD_RST;
         modBufReg <= MOD_RST;
         hiWrReg   <= 1'b0;
         loWrReg   <= 1'b0;
         cscReg    <= CSC_RST;
         cvalReg   <= CVAL_RST;
         chArmReg  <= 1'b0;
         inPrevReg <= 1'b0;
         outReg    <= 1'b0;
         rdReg     <= 8'h00;
      end
      else
      begin
         tscReg    <= tscNext;
         cntReg    <= cntNext;
         downReg   <= downNext;
         preReg    <= preNext;
         ovfArmReg <= ovfArmNext;
         modReg    <= modNext;
         modBufReg <= modBufNext;
         hiWrReg   <= hiWrNext;
         loWrReg   <= loWrNext;
         cscReg    <= cscNext;
         cvalReg   <= cvalNext;
         chArmReg  <= chArmNext;
         inPrevReg <= chanIn;
         outReg    <= outNext;
         rdReg     <= rdNext;
      end
   end

   assign rdData      = rdReg;
   assign chanOut     = outReg;
   // Pin released when edge/level is zero or capturing
   assign chanOe      = (els != ELS_OFF) && (mode != MODE_CAPT);
   assign overflowIrq = tscReg[OVF_BIT] && tscReg[OVFIE_BIT];
   assign chanIrq     = cscReg[CFLAG_BIT] && cscReg[CIE_BIT];

endmodule

// ==== tb/ptm_timer_props.sv ====
// Port-level checker for ptm_timer.
// Assumes it is bound into ptm_timer and sees only that module's ports.
`timescale 1ns/10ps
module ptm_timer_props
(
   input wire logic              clk,         // Bus clock
   input wire logic              srst,        // Synchronous reset
   input wire ptm_pkg::ptm_bus_t busReq,      // Register request
   input wire logic [7:0]        rdData,      // Read data
   input wire logic              debugHalt,   // Debug halt level
   input wire logic              chanIn,      // Channel pin input
   input wire logic              chanOe,      // Channel pin enable
   input wire logic              overflowIrq, // Overflow request
   input wire logic              chanIrq      // Channel request
);
   import ptm_pkg::*;

   logic       pendH_reg;
   logic       pendH_next;
   logic       pendL_reg;
   logic       pendL_next;
   logic       center_reg;
   logic       center_next;
   logic [6:2] csc_reg;
   logic [6:2] csc_next;
   logic       tscWr;
   logic       cscWr;
   logic       half;

   assign tscWr = busReq.wr && busReq.addr == TSC_OFS;
   assign cscWr = busReq.wr && busReq.addr == CSC_OFS;
   assign half  = pendH_reg ^ pendL_reg;

   // Shadow of the modulo byte latches; halt leaves them alone, a status/control write still clears them
   always_comb
   begin
      pendH_next  = pendH_reg;
      pendL_next  = pendL_reg;
      center_next = center_reg;
      csc_next    = csc_reg;
      if (busReq.wr && !debugHalt)
      begin
         pendH_next = pendH_reg | (busReq.addr == MODH_OFS);
         pendL_next = pendL_reg | (busReq.addr == MODL_OFS);
      end
      if ((pendH_next && pendL_next) || tscWr)
      begin
         pendH_next = 1'b0;
         pendL_next = 1'b0;
      end
      if (tscWr)
         center_next = busReq.wData[CPWM_BIT];
      if (cscWr)
         csc_next = busReq.wData[6:2];
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pendH_reg  <= 1'b0;
         pendL_reg  <= 1'b0;
         center_reg <= 1'b0;
         csc_reg    <= '0;
      end
      else
      begin
         pendH_reg  <= pendH_next;
         pendL_reg  <= pendL_next;
         center_reg <= center_next;
         csc_reg    <= csc_next;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   sequence capt_rise;
      csc_reg[6] && csc_reg[5:4] == 2'h0 && !center_reg && csc_reg[2] && $rose(chanIn);
   endsequence

   chk_rd_idle_zero: assert property (!$past(busReq.rd) |-> rdData == 8'h00)
      else $error("read data not zero outside read cycle");
   chk_ovf_half_mod: assert property ($rose(overflowIrq) && !$past(tscWr) |-> !$past(half))
      else $error("overflow raised with half-written modulo");
   chk_pin_release: assert property (cscWr && busReq.wData[3:2] == 2'h0 |=> !chanOe)
      else $error("pin driven with edge/level zero");
   chk_capt_no_drive: assert property (cscWr && busReq.wData[5:4] == 2'h0 && !center_reg |=> !chanOe)
      else $error("pin driven in capture mode");
   chk_epwm_drive: assert property (cscWr && busReq.wData[5] && busReq.wData[3:2] != 2'h0 |=> chanOe)
      else $error("pin not driven in edge PWM");
   chk_irq_mask: assert property (cscWr && !busReq.wData[CIE_BIT] |=> !chanIrq)
      else $error("channel request with enable clear");
   chk_flag_hold: assert property (chanIrq && !cscWr |=> chanIrq)
      else $error("channel flag dropped without a write");
   chk_ovf_hold: assert property (overflowIrq && !tscWr |=> overflowIrq)
      else $error("overflow request dropped without a write");
   chk_capt_flag: assert property (capt_rise |-> ##[1:3] chanIrq)
      else $error("rising edge not captured");
endmodule

bind ptm_timer ptm_timer_props u_ptm_timer_props (
   .clk(clk), .srst(srst), .busReq(busReq), .rdData(rdData), .debugHalt(debugHalt),
   .chanIn(chanIn), .chanOe(chanOe), .overflowIrq(overflowIrq), .chanIrq(chanIrq)
);

// ==== tb/ptm_timer_tb.sv ====
// Self-checking bench for ptm_timer.
// Assumes the design package, design and checker are compiled first.
`timescale 1ns/10ps
module ptm_timer_tb;
   import ptm_pkg::*;

   typedef struct {
      logic [2:0] wa;
      logic [7:0] wd;
      logic [2:0] ra;
      logic [7:0] re;
   } ptm_row_t;

   logic     clk;
   logic     srst;
   ptm_bus_t busReq;
   logic [7:0] rdData;
   logic     debugHalt;
   logic     fixedTick;
   logic     extTick;
   logic     chanIn;
   logic     chanOut;
   logic     chanOe;
   logic     overflowIrq;
   logic     chanIrq;
   logic [7:0] v;
   int       n;
   int       bad_count = 0;
   int       samples_checked = 0;

   ptm_row_t rows [9] = '{
      '{CSC_OFS,  8'hFF, CSC_OFS,  8'h7F},
      '{CSC_OFS,  8'h00, CSC_OFS,  8'h00},
      '{MODH_OFS, 8'hAB, MODH_OFS, 8'h00},
      '{MODL_OFS, 8'hCD, MODH_OFS, 8'hAB},
      '{MODL_OFS, 8'h11, MODL_OFS, 8'hCD},
      '{TSC_OFS,  8'h00, MODL_OFS, 8'hCD},
      '{MODH_OFS, 8'h00, MODH_OFS, 8'hAB},
      '{MODL_OFS, 8'h05, MODL_OFS, 8'h05},
      '{CSC_OFS,  8'h00, MODH_OFS, 8'h00}
   };

   ptm_timer u_ptm_timer (
      .clk(clk), .srst(srst), .busReq(busReq), .rdData(rdData), .debugHalt(debugHalt),
      .fixedTick(fixedTick), .extTick(extTick), .chanIn(chanIn), .chanOut(chanOut),
      .chanOe(chanOe), .overflowIrq(overflowIrq), .chanIrq(chanIrq)
   );

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic final_report;
      $display("bad_count=%0d samples_checked=%0d", bad_count, samples_checked);
      if (bad_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Each access ends just past its taking edge so results have landed
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      busReq <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      busReq <= '0;
      #1;
   endtask

   task automatic rc(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      busReq <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      busReq <= '0;
      #1 v = rdData;
      check(v, exp);
   endtask

   task automatic idle(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask

   task automatic await(ref logic s, input int lim);
      n = 0;
      while (s !== 1'b1 && n < lim)
      begin
         idle(1);
         n++;
      end
   endtask

   initial
   begin
      // About 80k cycles; the free-run wrap alone takes 65k
      #2000000;
      bad_count++;
      final_report();
   end

   initial
   begin
      srst = 1'b1;
      busReq = '0;
      debugHalt = 1'b0;
      fixedTick = 1'b0;
      extTick = 1'b0;
      chanIn = 1'b0;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      rc(MODH_OFS, MOD_RST[15:8]);
      rc(MODL_OFS, MOD_RST[7:0]);
      rc(CSC_OFS, CSC_RST);
      check(8'({chanOe, overflowIrq, chanIrq}), 8'h00);
      foreach (rows[i])
      begin
         wr(rows[i].wa, rows[i].wd);
         rc(rows[i].ra, rows[i].re);
      end
      // Modulo 5 on the bus clock, counter cleared first
      wr(CNTL_OFS, 8'h00);
      wr(TSC_OFS, 8'h48);
      await(overflowIrq, 20);
      check(8'(n >= 5 && n <= 8), 8'h01);
      wr(TSC_OFS, 8'h40);
      rc(CNTH_OFS, 8'h00);
      rc(TSC_OFS, 8'hC0);
      wr(TSC_OFS, 8'h40);
      check(8'(overflowIrq), 8'h00);
      wr(TSC_OFS, 8'h48);
      wr(MODH_OFS, 8'h00);
      idle(20);
      check(8'(overflowIrq), 8'h00);
      wr(MODL_OFS, 8'h05);
      await(overflowIrq, 20);
      check(8'(n < 20), 8'h01);
      // Divide by 128 so the buffered load is far off
      wr(TSC_OFS, 8'h0F);
      wr(CNTL_OFS, 8'h00);
      wr(MODH_OFS, 8'h00);
      wr(MODL_OFS, 8'h03);
      rc(MODL_OFS, 8'h05);
      idle(700);
      rc(MODL_OFS, 8'h03);
      wr(TSC_OFS, 8'h00);
      wr(MODL_OFS, 8'h44);
      debugHalt <= 1'b1;
      wr(MODH_OFS, 8'h12);
      rc(MODH_OFS, 8'h12);
      rc(MODL_OFS, 8'h03);
      debugHalt <= 1'b0;
      wr(MODH_OFS, 8'h00);
      rc(MODL_OFS, 8'h44);
      for (int e = 1; e < 4; e++)
      begin
         wr(CSC_OFS, 8'(8'h40 | (e << 2)));
         idle(3);
         chanIn <= 1'b1;
         idle(4);
         check(8'(chanIrq), 8'(e[0]));
         chanIn <= 1'b0;
         idle(4);
         check(8'(chanIrq), 8'h01);
         rc(CSC_OFS, 8'(8'hC0 | (e << 2)));
         wr(CSC_OFS, 8'(8'h40 | (e << 2)));
         check(8'(chanIrq), 8'h00);
      end
      wr(CSC_OFS, 8'h50);
      check(8'(chanOe), 8'h00);
      wr(CVH_OFS, 8'h00);
      wr(CVL_OFS, 8'h03);
      wr(CNTL_OFS, 8'h00);
      wr(TSC_OFS, 8'h08);
      await(chanIrq, 20);
      check(8'(n < 20), 8'h01);
      rc(CSC_OFS, 8'hD0);
      wr(CSC_OFS, 8'h5C);
      check(8'(chanOe), 8'h01);
      await(chanIrq, 100);
      idle(2);
      check(8'(chanOut), 8'h01);
      wr(TSC_OFS, 8'h00);
      rc(CSC_OFS, 8'hDC);
      wr(CSC_OFS, 8'h68);
      wr(CVL_OFS, 8'h00);
      wr(TSC_OFS, 8'h08);
      idle(150);
      check(8'(chanIrq), 8'h00);
      check(8'(chanOe), 8'h01);
      check(8'(chanOut), 8'h00);
      // Free run with a pending pair; load must wait for FFFE to FFFF
      wr(TSC_OFS, 8'h00);
      wr(MODH_OFS, 8'h00);
      wr(MODL_OFS, 8'h00);
      wr(CNTL_OFS, 8'h00);
      rc(TSC_OFS, 8'h80);
      wr(TSC_OFS, 8'h48);
      wr(MODH_OFS, 8'h00);
      wr(MODL_OFS, 8'h10);
      idle(65000);
      check(8'(overflowIrq), 8'h00);
      rc(MODL_OFS, 8'h00);
      await(overflowIrq, 1000);
      check(8'(n < 1000), 8'h01);
      rc(MODL_OFS, 8'h10);
      // Fixed and external sources count only their own pulses
      wr(TSC_OFS, 8'h10);
      wr(CNTL_OFS, 8'h00);
      idle(4);
      rc(CNTL_OFS, 8'h00);
      fixedTick <= 1'b1;
      idle(3);
      fixedTick <= 1'b0;
      rc(CNTL_OFS, 8'h03);
      wr(TSC_OFS, 8'h18);
      extTick <= 1'b1;
      idle(2);
      extTick <= 1'b0;
      fixedTick <= 1'b1;
      idle(2);
      fixedTick <= 1'b0;
      rc(CNTL_OFS, 8'h05);
      // Center PWM, high-true: clear counting up, set counting down
      wr(CVL_OFS, 8'h04);
      wr(CNTL_OFS, 8'h00);
      wr(TSC_OFS, 8'h28);
      await(chanIrq, 40);
      check(8'(n < 40), 8'h01);
      check(8'(chanOut), 8'h00);
      rc(CSC_OFS, 8'hE8);
      wr(CSC_OFS, 8'h68);
      await(chanIrq, 60);
      check(8'(chanOut), 8'h01);
      // Reset in mid-run with flag, pin and modulo all non-zero
      srst <= 1'b1;
      idle(3);
      srst <= 1'b0;
      check(8'({chanOut, chanOe, overflowIrq, chanIrq}), 8'h00);
      rc(MODL_OFS, MOD_RST[7:0]);
      rc(CSC_OFS, CSC_RST);
      final_report();
   end
endmodule
